// file: rtl/bac_pkg.sv
// shared constants, types and register map of the bridge converter control block
package bac_pkg;

  // clock and conversion timing
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned SLOW_SPS     = 10;
  localparam int unsigned FAST_SPS     = 80;
  localparam int unsigned SLOW_CYC_DEF = CLK_HZ / SLOW_SPS;
  localparam int unsigned FAST_CYC_DEF = CLK_HZ / FAST_SPS;
  localparam int unsigned SLEEP_US     = 100;
  localparam int unsigned SLEEP_CYC    = (SLEEP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned CNT_W        = 22;
  localparam int unsigned HI_W         = 12;

  // readout shape
  localparam int unsigned RES_W        = 24;
  localparam logic [4:0]  EDGE_LAST    = 5'd24;
  localparam logic [4:0]  EDGE_FORCE   = 5'd25;

  // register byte addresses
  localparam logic [7:0]  ADDR_STATUS  = 8'h00;
  localparam logic [7:0]  ADDR_MASK    = 8'h04;
  localparam logic [7:0]  ADDR_PINS    = 8'h08;
  localparam logic [7:0]  ADDR_RESULT  = 8'h0C;
  localparam logic [7:0]  ADDR_STATE   = 8'h10;

  // status and mask layout
  localparam int unsigned EV_W         = 5;
  localparam int unsigned EV_READY     = 0;
  localparam int unsigned EV_READOUT   = 1;
  localparam int unsigned EV_CAL       = 2;
  localparam int unsigned EV_SLEEP     = 3;
  localparam int unsigned EV_OVERRUN   = 4;
  localparam logic [EV_W-1:0] MASK_RST = 5'h00;

  // htrans codes
  localparam logic [1:0]  HTRANS_IDLE  = 2'b00;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'b10;

  typedef enum logic [5:0] {
    ST_CONV  = 6'b00_0001,
    ST_READY = 6'b00_0010,
    ST_SHIFT = 6'b00_0100,
    ST_DONE  = 6'b00_1000,
    ST_CAL   = 6'b01_0000,
    ST_SLEEP = 6'b10_0000
  } bac_state_e;

  // control pin levels after synchronising
  typedef struct packed {
    logic       speed;
    logic [1:0] gain;
    logic [1:0] mux;
  } bac_pins_s;

  // settings handed to the analog front end
  typedef struct packed {
    logic       power_down;
    logic       temp_en;
    logic [1:0] chan;
    logic [1:0] gain_code;
    logic       cal_run;
    logic       sleep;
  } bac_ana_s;

endpackage

// file: rtl/bac_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
module bac_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_ff <= '0;
      q       <= '0;
    end
    else
    begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// file: rtl/bac_adc_core.sv
// pin control, conversion timing and serial readout of the bridge converter
`timescale 1ns/1ps
// Operation
// - while the power-down pin is low the converter is powered down and its logic held in reset.
// - result bits move out on the ready/data line on rising edges of the shift clock.
// - extra shift clock edges start offset calibration and a long high shift clock enters sleep.
// - the ready/data line goes low when a result is ready and then carries the serial data.
// - bits leave MSB first, the first one on the first rising shift edge after ready.
// - each result is a 24-bit word.
// - there are no programmable converter settings; all come from control pin levels.
// - readout needs only the shift clock and the ready/data line.
// - the only output data rates are ten and eighty conversions per second.
// - on the four-channel part the mux pins 00/01/10/11 pick input pairs 1, 2, 3 and 4.
// - on the two-channel part the upper mux pin enables the thermal diodes instead.
// - single-ended inputs give only positive codes, half the full-scale range.
// - gain pins 00/01/10/11 give gains 1, 2, 64 and 128, upper pin as MSB.
// - a low rate pin gives ten, a high one eighty conversions per second.
// - with thermal diodes enabled the analog inputs are cut off and the diodes measured.
module bac_adc_core
  import bac_pkg::*;
#(
  parameter int unsigned SLOW_CYC = bac_pkg::SLOW_CYC_DEF,
  parameter int unsigned FAST_CYC = bac_pkg::FAST_CYC_DEF,
  parameter bit          FOUR_CH  = 1'b1
) (
  // clock and reset
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  // ahb-lite slave
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  // control pins
  input  wire logic                 power_down_pin,
  input  wire logic                 rate_sel,
  input  wire logic                 gain_sel_hi,
  input  wire logic                 gain_sel_lo,
  input  wire logic                 mux_sel_hi,
  input  wire logic                 mux_sel_lo,
  // serial link
  input  wire logic                 serial_clk,
  output logic                      ready_and_result_out,
  // filter result and analog control
  input  wire logic [RES_W-1:0]     sample_data,
  output bac_pkg::bac_ana_s         ana_ctrl,
  // interrupt
  output logic                      irq
);

  localparam logic [CNT_W-1:0] SLOW_P = SLOW_CYC[CNT_W-1:0];
  localparam logic [CNT_W-1:0] FAST_P = FAST_CYC[CNT_W-1:0];
  localparam logic [HI_W-1:0]  SLP_P  = SLEEP_CYC[HI_W-1:0];

  // pair number for a mux code, two-channel part ignores the upper pin
  function automatic logic [1:0] chan_of(input logic [1:0] mux);
    chan_of = FOUR_CH ? mux : {1'b0, mux[0]};
  endfunction

  // synchronised pins
  logic [6:0]             sync_q;
  logic                   pd_n_s;
  logic                   sclk_s;
  bac_pins_s              pins_s;

  bac_sync #(.W(7)) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({power_down_pin, serial_clk, rate_sel, gain_sel_hi, gain_sel_lo,
             mux_sel_hi, mux_sel_lo}),
    .q     (sync_q)
  );

  assign pd_n_s = sync_q[6];
  assign sclk_s = sync_q[5];
  assign pins_s = bac_pins_s'(sync_q[4:0]);

  // state
  bac_state_e             st_ff;
  bac_pins_s              pins_ff;
  logic                   sclk_ff;
  logic [CNT_W-1:0]       cnt_ff;
  logic [HI_W-1:0]        hi_ff;
  logic [4:0]             edge_ff;
  logic [RES_W-1:0]       shift_ff;
  logic [RES_W-1:0]       result_ff;
  logic                   dout_ff;
  bac_ana_s               ana_ff;
  logic [EV_W-1:0]        status_ff;
  logic [EV_W-1:0]        mask_ff;
  logic                   irq_ff;
  logic [31:0]            hrdata_ff;
  logic                   wr_pend_ff;
  logic [7:0]             wr_addr_ff;

  // decode of link and timing conditions
  logic [CNT_W-1:0]       period_w;
  logic                   run_w;
  logic                   cfg_chg_w;
  logic                   conv_done_w;
  logic                   sclk_rise_w;
  logic                   sleep_hit_w;
  logic                   cal_end_w;
  logic [EV_W-1:0]        ev_w;

  assign period_w    = pins_s.speed ? FAST_P : SLOW_P;
  assign run_w       = (st_ff != ST_CAL) && (st_ff != ST_SLEEP);
  assign cfg_chg_w   = (pins_s != pins_ff);
  assign conv_done_w = pd_n_s && run_w && !cfg_chg_w && (cnt_ff == period_w - 1'b1);
  assign sclk_rise_w = pd_n_s && sclk_s && !sclk_ff;
  assign sleep_hit_w = pd_n_s && sclk_s && (hi_ff == SLP_P - 1'b1)
                       && (st_ff != ST_CAL) && (st_ff != ST_SLEEP);
  assign cal_end_w   = pd_n_s && (st_ff == ST_CAL) && (cnt_ff == period_w - 1'b1);

  assign ev_w[EV_READY]   = conv_done_w && !sleep_hit_w && (st_ff != ST_SHIFT);
  assign ev_w[EV_READOUT] = sclk_rise_w && (st_ff == ST_SHIFT) && (edge_ff == EDGE_LAST - 1'b1);
  assign ev_w[EV_CAL]     = cal_end_w;
  assign ev_w[EV_SLEEP]   = sleep_hit_w;
  assign ev_w[EV_OVERRUN] = conv_done_w && !sleep_hit_w && (st_ff == ST_SHIFT);

  // settings snapshot, shift clock history and high-time counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pins_ff <= '0;
      sclk_ff <= 1'b0;
      hi_ff   <= '0;
    end
    else
    begin
      pins_ff <= pins_s;
      sclk_ff <= sclk_s;
      hi_ff   <= (sclk_s && pd_n_s && hi_ff != SLP_P) ? hi_ff + 1'b1 : '0;
    end
  end

  // conversion and calibration timer
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_ff <= '0;
    else if (!pd_n_s || cfg_chg_w || conv_done_w || cal_end_w || sleep_hit_w)
      cnt_ff <= '0;
    else if (st_ff == ST_SLEEP)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + 1'b1;
  end

  // readout state machine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_ff     <= ST_CONV;
      edge_ff   <= '0;
      shift_ff  <= '0;
      result_ff <= '0;
      dout_ff   <= 1'b1;
    end
    else if (!pd_n_s)
    begin
      st_ff    <= ST_CONV;
      edge_ff  <= '0;
      shift_ff <= '0;
      dout_ff  <= 1'b1;
    end
    else if (sleep_hit_w)
    begin
      st_ff   <= ST_SLEEP;
      dout_ff <= 1'b1;
    end
    else
    begin
      case (st_ff)
        ST_CONV, ST_READY, ST_DONE:
        begin
          if (st_ff == ST_READY && sclk_rise_w)
          begin
            dout_ff  <= shift_ff[RES_W-1];
            shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
            edge_ff  <= 5'd1;
            st_ff    <= ST_SHIFT;
          end
          else if (st_ff == ST_DONE && sclk_rise_w)
          begin
            st_ff <= ST_CAL;
          end
          else if (conv_done_w)
          begin
            shift_ff  <= sample_data;
            result_ff <= sample_data;
            dout_ff   <= 1'b0;
            edge_ff   <= '0;
            st_ff     <= ST_READY;
          end
        end
        ST_SHIFT:
        begin
          if (sclk_rise_w)
          begin
            edge_ff <= edge_ff + 1'b1;
            if (edge_ff < EDGE_LAST)
            begin
              dout_ff  <= shift_ff[RES_W-1];
              shift_ff <= {shift_ff[RES_W-2:0], 1'b0};
            end
            else
            begin
              dout_ff <= 1'b1;
              st_ff   <= ST_DONE;
            end
          end
        end
        ST_CAL:
        begin
          if (cal_end_w)
            st_ff <= ST_CONV;
        end
        ST_SLEEP:
        begin
          if (!sclk_s)
            st_ff <= ST_CONV;
        end
        default:
          st_ff <= ST_CONV;
      endcase
    end
  end

  // analog front-end settings, registered from the pins and the readout state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      ana_ff <= '{power_down: 1'b1, default: '0};
    else
    begin
      ana_ff.power_down <= !pd_n_s;
      ana_ff.temp_en    <= !FOUR_CH && pins_s.mux[1];
      ana_ff.chan       <= chan_of(pins_s.mux);
      ana_ff.gain_code  <= pins_s.gain;
      ana_ff.cal_run    <= pd_n_s && (st_ff == ST_CAL);
      ana_ff.sleep      <= pd_n_s && (st_ff == ST_SLEEP);
    end
  end

  // bus decode
  logic                   acc_w;
  logic                   rd_w;
  logic                   stat_rd_w;
  logic [31:0]            rdata_w;
  logic [EV_W-1:0]        nxt_status;

  assign acc_w     = hsel && hready && (htrans == HTRANS_NSEQ);
  assign rd_w      = acc_w && !hwrite;
  assign stat_rd_w = rd_w && (haddr[7:0] == ADDR_STATUS);
  assign rdata_w   = (haddr[7:0] == ADDR_STATUS) ? {27'h000_0000, status_ff} :
                     (haddr[7:0] == ADDR_MASK)   ? {27'h000_0000, mask_ff} :
                     (haddr[7:0] == ADDR_PINS)   ? {24'h00_0000, !pd_n_s, ana_ff.temp_en,
                                                    pins_s.speed, pins_s.gain,
                                                    chan_of(pins_s.mux), 1'b0} :
                     (haddr[7:0] == ADDR_RESULT) ? {8'h00, result_ff} :
                     (haddr[7:0] == ADDR_STATE)  ? {26'h000_0000, st_ff} :
                     32'h0000_0000;
  assign nxt_status = (stat_rd_w ? '0 : status_ff) | ev_w;

  // ahb-lite register access
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata_ff  <= 32'h0000_0000;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      mask_ff    <= MASK_RST;
      status_ff  <= '0;
      irq_ff     <= 1'b0;
    end
    else
    begin
      if (rd_w)
        hrdata_ff <= rdata_w;
      wr_pend_ff <= acc_w && hwrite;
      wr_addr_ff <= haddr[7:0];
      if (wr_pend_ff && wr_addr_ff == ADDR_MASK)
        mask_ff <= hwdata[EV_W-1:0];
      status_ff <= nxt_status;
      irq_ff    <= |(nxt_status & mask_ff);
    end
  end

  assign hrdata               = hrdata_ff;
  assign hreadyout            = 1'b1;
  assign hresp                = 1'b0;
  assign ready_and_result_out = dout_ff;
  assign ana_ctrl             = ana_ff;
  assign irq                  = irq_ff;

endmodule

// file: sim/bac_host.sv
// host model: drives the shift clock and reads the ready/data line
`timescale 1ns/1ps
module bac_host (
  // clock in
  input  wire logic hclk,
  // two-wire link
  output logic      serial_clk,
  input  wire logic dout
);
  initial serial_clk = 1'b0;
  // hold the shift clock at a level for n cycles
  task automatic drive(input logic lvl, input int n);
    serial_clk <= lvl;
    repeat (n) @(posedge hclk);
  endtask
  // one 160 ns high pulse then 160 ns low, line sampled before the next rise
  task automatic pulse(output logic b);
    drive(1'b1, 4);
    drive(1'b0, 4);
    b = dout;
  endtask
  // 24 bits msb first, then the closing edge
  task automatic get_word(output logic [23:0] w, output logic last);
    for (int i = 23; i >= 0; i--)
      pulse(w[i]);
    pulse(last);
  endtask
endmodule

// file: sim/bac_adc_core_asserts.sv
// pin-level checks of the bridge converter control block
`timescale 1ns/1ps
module bac_chk
  import bac_pkg::*;
#(
  parameter bit FOUR_CH = 1'b1
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // bus answer
  input wire logic              hreadyout,
  input wire logic              hresp,
  // control pins
  input wire logic              power_down_pin,
  input wire logic              gain_sel_hi,
  input wire logic              gain_sel_lo,
  input wire logic              mux_sel_hi,
  input wire logic              mux_sel_lo,
  // link and analog side
  input wire logic              serial_clk,
  input wire logic              ready_and_result_out,
  input wire bac_pkg::bac_ana_s ana_ctrl
);
  localparam int unsigned SLEEP_LIM = SLEEP_CYC + 20;
  logic [11:0] hi_cnt_ff;
  logic [11:0] nxt_hi_cnt;
  // cycles of shift clock held high
  assign nxt_hi_cnt = (!serial_clk || !power_down_pin) ? 12'h000 :
                      (hi_cnt_ff == 12'hFFF) ? hi_cnt_ff : hi_cnt_ff + 12'h001;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      hi_cnt_ff <= 12'h000;
    else
      hi_cnt_ff <= nxt_hi_cnt;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_power_off_hold: assert property (!power_down_pin [*4] |=>
    ready_and_result_out && ana_ctrl.power_down)
    else $error("power-down hold missing");
  chk_gain_map: assert property ((power_down_pin && $stable({gain_sel_hi, gain_sel_lo})) [*5]
    |-> ana_ctrl.gain_code == {gain_sel_hi, gain_sel_lo})
    else $error("gain code does not follow pins");
  chk_chan_map: assert property ((power_down_pin && $stable({mux_sel_hi, mux_sel_lo})) [*5]
    |-> ana_ctrl.chan == (FOUR_CH ? {mux_sel_hi, mux_sel_lo} : {1'b0, mux_sel_lo}))
    else $error("channel does not follow pins");
  chk_diode_map: assert property ((power_down_pin && $stable(mux_sel_hi)) [*5]
    |-> ana_ctrl.temp_en == (!FOUR_CH && mux_sel_hi))
    else $error("diode enable does not follow pin");
  chk_idle_quiet: assert property ((!serial_clk && power_down_pin) [*8]
    |-> !$rose(ready_and_result_out))
    else $error("data line rose without shift edge");
  chk_ready_hold: assert property ($fell(ready_and_result_out) && !serial_clk && power_down_pin
    |=> !ready_and_result_out [*2])
    else $error("ready low not held");
  chk_sleep_entry: assert property (hi_cnt_ff == SLEEP_LIM
    |-> ready_and_result_out && ana_ctrl.sleep)
    else $error("sleep not entered");
endmodule
bind bac_adc_core bac_chk #(.FOUR_CH(FOUR_CH)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .power_down_pin(power_down_pin), .gain_sel_hi(gain_sel_hi), .gain_sel_lo(gain_sel_lo),
  .mux_sel_hi(mux_sel_hi), .mux_sel_lo(mux_sel_lo), .serial_clk(serial_clk),
  .ready_and_result_out(ready_and_result_out), .ana_ctrl(ana_ctrl));

// file: sim/tb_bac_adc_core.sv
// self-checking bench of the bridge converter control block
`timescale 1ns/1ps
module tb_bac_adc_core;
  import bac_pkg::*;
  localparam int SLOW = 800;
  localparam int FAST = 400;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = HTRANS_IDLE, gain = 2'h0, mux = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata;
  logic        hreadyout, hresp, sclk, dout, irq, pdn = 1'b1, rate = 1'b1;
  logic [23:0] sample = 24'hA5_3C96;
  bac_ana_s    ana;
  bac_ana_s    ana_two;
  int          mismatches = 0, checked = 0;
  always #20 hclk = ~hclk;
  bac_adc_core #(.SLOW_CYC(SLOW), .FAST_CYC(FAST)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .power_down_pin(pdn), .rate_sel(rate),
    .gain_sel_hi(gain[1]), .gain_sel_lo(gain[0]), .mux_sel_hi(mux[1]), .mux_sel_lo(mux[0]),
    .serial_clk(sclk), .ready_and_result_out(dout), .sample_data(sample),
    .ana_ctrl(ana), .irq(irq));
  // two-channel build, same pins, off the bus
  bac_adc_core #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .FOUR_CH(1'b0)) dut_two_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b0), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(),
    .hreadyout(), .hresp(), .power_down_pin(pdn), .rate_sel(rate),
    .gain_sel_hi(gain[1]), .gain_sel_lo(gain[0]), .mux_sel_hi(mux[1]), .mux_sel_lo(mux[0]),
    .serial_clk(sclk), .ready_and_result_out(), .sample_data(sample),
    .ana_ctrl(ana_two), .irq());
  bac_host host_u (.hclk(hclk), .serial_clk(sclk), .dout(dout));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic give_up;
    mismatches++;
    summarize();
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
    begin
      n++;
      if (n > 50)
        give_up();
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= HTRANS_NSEQ;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wait_low(output int n);
    n = 0;
    while (dout !== 1'b0)
    begin
      @(posedge hclk);
      n++;
      if (n > 4 * SLOW)
        give_up();
    end
  endtask
  initial
  begin
    logic [31:0] d;
    logic [23:0] w;
    logic        b;
    int          n;
    int          p;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, ADDR_MASK, 0, d);
    check(d, 32'h0000_0000);
    bus(1'b1, ADDR_MASK, 32'h0000_001F, d);
    bus(1'b0, ADDR_STATUS, 0, d);
    wait_low(n);
    repeat (2) @(posedge hclk);
    check(irq, 1);
    host_u.get_word(w, b);
    check(w, sample);
    bus(1'b0, ADDR_RESULT, 0, d);
    check(d, {8'h00, sample});
    check(b, 1);
    bus(1'b0, ADDR_STATUS, 0, d);
    check(d, 32'h0000_0003);
    repeat (2) @(posedge hclk);
    check(irq, 0);
    $display("test readout done");
    host_u.pulse(b);
    bus(1'b0, ADDR_STATE, 0, d);
    check(d, 32'h0000_0010);
    check(ana.cal_run, 1);
    wait_low(n);
    host_u.drive(1'b1, 2600);
    bus(1'b0, ADDR_STATE, 0, d);
    check(d, 32'h0000_0020);
    check(dout, 1);
    bus(1'b1, ADDR_MASK, 32'h0000_0008, d);
    repeat (2) @(posedge hclk);
    check(irq, 1);
    bus(1'b1, ADDR_MASK, 32'h0000_0000, d);
    repeat (2) @(posedge hclk);
    check(irq, 0);
    bus(1'b0, ADDR_STATUS, 0, d);
    check(d & 32'h0000_000C, 32'h0000_000C);
    host_u.drive(1'b0, 4);
    $display("test calibration and sleep done");
    for (int i = 0; i < 4; i++)
    begin
      wait_low(n);
      host_u.get_word(w, b);
      check(w, sample);
      gain   <= i[1:0];
      mux    <= 2'(3 - i);
      rate   <= i[0];
      sample <= ~sample;
      p = i[0] ? FAST : SLOW;
      @(posedge hclk);
      wait_low(n);
      check(n >= p && n <= p + 8, 1);
      bus(1'b0, ADDR_PINS, 0, d);
      check(d, {24'h00_0000, 2'h0, i[0], i[1:0], 2'(3 - i), 1'b0});
      check({ana_two.temp_en, ana_two.chan}, {!i[1], 1'b0, !i[0]});
    end
    $display("test pins and rates done");
    pdn <= 1'b0;
    repeat (6) @(posedge hclk);
    check(dout, 1);
    check(ana.power_down, 1);
    bus(1'b0, ADDR_PINS, 0, d);
    check(d[7], 1);
    pdn <= 1'b1;
    @(posedge hclk);
    wait_low(n);
    check(n >= FAST && n <= FAST + 8, 1);
    $display("test power down done");
    summarize();
  end
endmodule
